// *** core/vipc_pkg.sv ***
package vipc_pkg;
  // ---------------------------------------------------------------
  // vector table layout (byte addresses in program memory)
  // ---------------------------------------------------------------
  localparam logic [23:0] RESET_GOTO_ADDR = 24'h000000;
  localparam logic [23:0] RESET_TARGET_ADDR = 24'h000002;
  localparam logic [23:0] TRAP_BASE_ADDR = 24'h000004;
  localparam logic [23:0] TRAP_LAST_ADDR = 24'h000012;
  localparam logic [23:0] IRQ_BASE_ADDR = 24'h000014;
  localparam logic [23:0] IRQ_LAST_ADDR = 24'h0000fe;
  localparam logic [23:0] ALT_TABLE_OFFSET = 24'h000100;
  localparam logic [23:0] ALT_IRQ_BASE_ADDR = 24'h000114;
  localparam logic [23:0] ALT_IRQ_LAST_ADDR = 24'h0001fe;
  localparam logic [23:0] USER_CODE_ADDR = 24'h000200;
  localparam int NUM_VECTORS = 118;
  localparam int NUM_FLAG_REGS = 5;
  localparam int NUM_PRIO_REGS = 21;
  localparam int NUM_SRC = 80;
  // trap slots
  localparam logic [2:0] TRAP_OSC = 3'h1;
  localparam logic [2:0] TRAP_ADDR = 3'h2;
  localparam logic [2:0] TRAP_STACK = 3'h3;
  localparam logic [2:0] TRAP_ARITH = 3'h4;
  // ---------------------------------------------------------------
  // register map (wishbone byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_TEST_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ALU_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_CORE_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_FLAG_BASE = 8'h20;
  localparam logic [7:0] ADDR_ENABLE_BASE = 8'h40;
  localparam logic [7:0] ADDR_PRIO_BASE = 8'h80;
  // field positions
  localparam int NEST_DIS_BIT = 15;
  localparam int ALT_SEL_BIT = 15;
  localparam int ARITH_BIT = 4;
  localparam int ADDRT_BIT = 3;
  localparam int STACK_BIT = 2;
  localparam int OSC_BIT = 1;
  localparam int LEVEL_LSB = 5;
  localparam int LEVEL_TOP_BIT = 3;
  localparam logic [15:0] CTRL_ONE_MASK = 16'h801e;
  localparam logic [15:0] CTRL_TWO_MASK = 16'h8007;
  localparam logic [15:0] ALU_STATUS_MASK = 16'h00ff;
  localparam logic [15:0] ZERO16 = 16'h0000;
  // bitmap of vectors that have a source; others never request
  localparam logic [NUM_SRC-1:0] SRC_IMPL = {
    8'h21, 8'h0e, 8'h40, 8'h06, 8'h22, 8'he3,
    16'hfe1f, 16'h3fef
  };
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [6:0] vector;
    logic [3:0] level;
    logic [23:0] fetch_addr;
  } vipc_req_t;
  typedef struct packed {
    logic osc;
    logic addr;
    logic stack;
    logic arith;
  } vipc_trap_t;
endpackage

// *** core/vipc_ctrl.sv ***
// Overview of operation
// - reset fetch starts at word zero, target next
// - eight trap slots from 0x04 to 0x12
// - vector n fetched at 0x14 plus 2n
// - alternate table sits 0x100 above primary
// - each source fixed to one vector number
// - control, flag, enable, priority, status registers exist
// - flags set by source, cleared by software
// - enable bit gates each flag
// - writable three-bit priority per source
// - flag/enable/priority placed by vector number
// - same level ties go to lowest vector
// - status bits 7:5 hold writable cpu level
// - level seven blocks all user interrupts
// - core control bit 3 extends level to four bits
// - top level bit only readable and clearable
// - nesting disable makes level bits read-only
// - new request latches vector and level
// - alternate select moves trap and interrupt fetches to alternate table; reset fetch stays at zero
// - each slot holds 24-bit routine start address
// - nesting disable blocks preemption of running routine
// - control one bit 4 flags arithmetic trap
//
// Decided for this implementation: the Wishbone slave port and the address map.
module vipc_ctrl
  import vipc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // peripheral request pulses, indexed by vector number
  input wire logic [NUM_SRC-1:0] src_event_i,
  input wire vipc_trap_t trap_event_i,
  // cpu side
  input wire logic isr_enter_i,
  input wire logic isr_exit_i,
  input wire logic trap_enter_i,
  output vipc_req_t irq_req_o,
  output logic [23:0] trap_fetch_addr_o,
  output logic [23:0] reset_fetch_addr_o,
  output logic in_service_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0] flag_reg [NUM_FLAG_REGS];
  logic [15:0] enable_reg [NUM_FLAG_REGS];
  logic [15:0] prio_reg [NUM_PRIO_REGS];
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  logic [15:0] test_status_reg;
  logic [2:0] cpu_level_low_bits;
  logic cpu_level_top_bit;
  logic [3:0] isr_depth_reg;
  logic [3:0] cpu_level;
  logic wr_stb;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [6:0] widx;
  vipc_req_t best_next;
  vipc_req_t req_reg;
  logic [31:0] rd_next;

  assign wr_stb = cyc_i && stb_i && we_i && !ack_o;
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdata = dat_i[15:0];
  assign widx = 7'(adr_i[6:2]);
  assign cpu_level = {cpu_level_top_bit, cpu_level_low_bits};

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one registered ack the cycle after the request; deasserts the cycle after so each access is single
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // ---------------------------------------------------------------
  // request flags and enables
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < NUM_FLAG_REGS; r++) begin
        flag_reg[r] <= ZERO16;
        enable_reg[r] <= ZERO16;
      end
    end else begin
      for (int r = 0; r < NUM_FLAG_REGS; r++) begin
        logic [15:0] f;
        f = flag_reg[r];
        if (wr_stb && adr_i == ADDR_FLAG_BASE + 8'(r * 4)) begin
          f = (f & ~wmask) | (wdata & wmask);
        end
        if (wr_stb && adr_i == ADDR_ENABLE_BASE + 8'(r * 4)) begin
          enable_reg[r] <= (enable_reg[r] & ~wmask) | (wdata & wmask);
        end
        for (int b = 0; b < 16; b++) begin
          // a source event wins over a same-cycle software clear
          if (r * 16 + b < NUM_SRC) begin
            if (src_event_i[r * 16 + b] && SRC_IMPL[r * 16 + b]) begin
              f[b] = 1'b1;
            end
          end
        end
        flag_reg[r] <= f;
      end
    end
  end

  // ---------------------------------------------------------------
  // priority fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int r = 0; r < NUM_PRIO_REGS; r++) begin
        prio_reg[r] <= ZERO16;
      end
    end else if (wr_stb && adr_i >= ADDR_PRIO_BASE && widx < 7'(NUM_PRIO_REGS)) begin
      // only the three-bit fields are stored; gaps read as zero
      prio_reg[widx[4:0]] <= (prio_reg[widx[4:0]] & ~wmask) | (wdata & wmask & 16'h7777);
    end
  end

  // ---------------------------------------------------------------
  // global controls and trap status
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_reg <= ZERO16;
      ctrl_two_reg <= ZERO16;
    end else begin
      logic [15:0] c;
      c = ctrl_one_reg;
      if (wr_stb && adr_i == ADDR_CTRL_ONE) begin
        c = (c & ~(wmask & CTRL_ONE_MASK)) | (wdata & wmask & CTRL_ONE_MASK);
      end
      // trap events set after the write so they win over a clear
      if (trap_event_i.arith) c[ARITH_BIT] = 1'b1;
      if (trap_event_i.addr) c[ADDRT_BIT] = 1'b1;
      if (trap_event_i.stack) c[STACK_BIT] = 1'b1;
      if (trap_event_i.osc) c[OSC_BIT] = 1'b1;
      ctrl_one_reg <= c;
      if (wr_stb && adr_i == ADDR_CTRL_TWO) begin
        ctrl_two_reg <= (ctrl_two_reg & ~(wmask & CTRL_TWO_MASK))
                        | (wdata & wmask & CTRL_TWO_MASK);
      end
    end
  end

  // ---------------------------------------------------------------
  // cpu priority level
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_level_low_bits <= 3'h0;
    end else if (trap_enter_i) begin
      cpu_level_low_bits <= 3'h7;
    end else if (wr_stb && adr_i == ADDR_ALU_STATUS && sel_i[0]
                 && !ctrl_one_reg[NEST_DIS_BIT]) begin
      cpu_level_low_bits <= wdata[LEVEL_LSB +: 3];
    end else if (isr_enter_i && !ctrl_one_reg[NEST_DIS_BIT]) begin
      cpu_level_low_bits <= req_reg.level[2:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_level_top_bit <= 1'b0;
    end else if (trap_enter_i) begin
      cpu_level_top_bit <= 1'b1;
    end else if (wr_stb && adr_i == ADDR_CORE_CONTROL && sel_i[0]
                 && !wdata[LEVEL_TOP_BIT]) begin
      cpu_level_top_bit <= 1'b0;
    end
  end

  // nesting depth tracks whether a routine is running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      isr_depth_reg <= 4'h0;
    end else if (isr_enter_i && !isr_exit_i && isr_depth_reg != 4'hf) begin
      isr_depth_reg <= isr_depth_reg + 4'h1;
    end else if (isr_exit_i && !isr_enter_i && isr_depth_reg != 4'h0) begin
      isr_depth_reg <= isr_depth_reg - 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  // a flat scan over 80 sources; long combinational path traded for one registered cycle of latency
  always_comb begin
    logic [2:0] p;
    logic [6:0] v;
    p = 3'h0;
    v = 7'h0;
    best_next = '0;
    for (int n = 0; n < NUM_SRC; n++) begin
      v = 7'(n);
      p = prio_reg[n / 4][4 * (n % 4) +: 3];
      if (SRC_IMPL[n] && flag_reg[n / 16][n % 16] && enable_reg[n / 16][n % 16]
          && {1'b0, p} > cpu_level
          && (!best_next.valid || p > best_next.level[2:0])) begin
        best_next.valid = 1'b1;
        best_next.vector = v;
        best_next.level = {1'b0, p};
        best_next.fetch_addr = (ctrl_two_reg[ALT_SEL_BIT] ? ALT_IRQ_BASE_ADDR : IRQ_BASE_ADDR)
                               + {16'h0000, v, 1'b0};
      end
    end
    // no preemption while a routine runs with nesting disabled
    if (ctrl_one_reg[NEST_DIS_BIT] && isr_depth_reg != 4'h0) begin
      best_next.valid = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_reg <= '0;
    end else begin
      req_reg <= best_next;
    end
  end
  assign irq_req_o = req_reg;

  // latch vector and level of each new request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_status_reg <= ZERO16;
    end else if (best_next.valid && (!req_reg.valid || best_next.vector != req_reg.vector)) begin
      test_status_reg <= {4'h0, best_next.level, 1'b0, best_next.vector};
    end
  end

  // ---------------------------------------------------------------
  // trap and reset fetch addresses
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trap_fetch_addr_o <= TRAP_BASE_ADDR;
      reset_fetch_addr_o <= RESET_GOTO_ADDR;
      in_service_o <= 1'b0;
    end else begin
      // highest natural order trap wins: lowest slot number
      logic [2:0] slot;
      slot = TRAP_ARITH;
      if (ctrl_one_reg[STACK_BIT]) slot = TRAP_STACK;
      if (ctrl_one_reg[ADDRT_BIT]) slot = TRAP_ADDR;
      if (ctrl_one_reg[OSC_BIT]) slot = TRAP_OSC;
      trap_fetch_addr_o <= (ctrl_two_reg[ALT_SEL_BIT] ? TRAP_BASE_ADDR + ALT_TABLE_OFFSET
                            : TRAP_BASE_ADDR) + {20'h00000, slot, 1'b0};
      reset_fetch_addr_o <= RESET_GOTO_ADDR;
      in_service_o <= isr_depth_reg != 4'h0;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_next = 32'h00000000;
    unique case (1'b1)
      adr_i == ADDR_CTRL_ONE: rd_next = {16'h0000, ctrl_one_reg};
      adr_i == ADDR_CTRL_TWO: rd_next = {16'h0000, ctrl_two_reg};
      adr_i == ADDR_TEST_STATUS: rd_next = {16'h0000, test_status_reg};
      adr_i == ADDR_ALU_STATUS: rd_next = {24'h000000, cpu_level_low_bits, 5'h00};
      adr_i == ADDR_CORE_CONTROL: rd_next = {28'h0000000, cpu_level_top_bit, 3'h0};
      adr_i >= ADDR_FLAG_BASE && adr_i < ADDR_FLAG_BASE + 8'h14:
        rd_next = {16'h0000, flag_reg[3'(widx - 7'h08)]};
      adr_i >= ADDR_ENABLE_BASE && adr_i < ADDR_ENABLE_BASE + 8'h14:
        rd_next = {16'h0000, enable_reg[3'(widx - 7'h10)]};
      adr_i >= ADDR_PRIO_BASE && widx < 7'(NUM_PRIO_REGS):
        rd_next = {16'h0000, prio_reg[widx[4:0]]};
      default: rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      dat_o <= rd_next;
    end
  end
endmodule

// *** dv/vipc_ctrl_chk.sv ***
module vipc_ctrl_chk
  import vipc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire vipc_req_t irq_req_o,
  input wire logic [23:0] trap_fetch_addr_o,
  input wire logic [23:0] reset_fetch_addr_o,
  input wire logic in_service_o
);
  // ----------
  // shadow of the nesting disable bit, seen on the bus
  // ----------
  logic nest_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nest_reg <= 1'b0;
    end else if (ack_o && we_i && sel_i[1] && adr_i == ADDR_CTRL_ONE) begin
      nest_reg <= dat_i[NEST_DIS_BIT];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------
  // properties
  // ----------
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_reset_vector: assert property (reset_fetch_addr_o == 24'h000000)
    else $error("reset fetch address not zero");
  a_irq_fetch_addr: assert property (irq_req_o.valid |->
    irq_req_o.fetch_addr == 24'h000014 + {16'h0, irq_req_o.vector, 1'b0} ||
    irq_req_o.fetch_addr == 24'h000114 + {16'h0, irq_req_o.vector, 1'b0})
    else $error("request fetch address off its vector slot");
  a_irq_source: assert property (irq_req_o.valid |->
    irq_req_o.vector < NUM_SRC && SRC_IMPL[irq_req_o.vector])
    else $error("request from a vector with no source");
  a_irq_level: assert property (irq_req_o.valid |-> irq_req_o.level inside {[1:7]})
    else $error("request at priority zero or trap level");
  a_trap_window: assert property (trap_fetch_addr_o[23:9] == 15'h0 &&
    !trap_fetch_addr_o[0] && trap_fetch_addr_o[7:0] inside {[8'h04:8'h12]})
    else $error("trap fetch address outside trap slots");
  a_nest_blocks: assert property ((in_service_o && nest_reg)[*3] |-> !irq_req_o.valid)
    else $error("request offered while nesting disabled in service");
endmodule

// *** dv/vipc_cpu_model.sv ***
module vipc_cpu_model
  import vipc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire vipc_req_t req_i,
  input wire logic en_i,
  input wire logic slow_i,
  output logic enter_o,
  output logic exit_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // cpu: takes the offered vector, runs a routine, returns
  // ----------
  // the routine never clears its flag, so the bench must drop en_i
  initial begin
    enter_o = 1'b0;
    exit_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (en_i && !rst_i && req_i.valid === 1'b1) begin
        repeat (slow_i ? 4 : 0) @(posedge clk_i);
        enter_o <= 1'b1;
        @(posedge clk_i);
        enter_o <= 1'b0;
        repeat (slow_i ? 40 : 6) @(posedge clk_i);
        exit_o <= 1'b1;
        @(posedge clk_i);
        exit_o <= 1'b0;
      end
    end
  end
endmodule

// *** dv/vipc_ctrl_tb.sv ***
module vipc_ctrl_tb
  import vipc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic [NUM_SRC-1:0] src_event_i = '0;
  vipc_trap_t trap_event_i = '0;
  logic trap_enter_i = 1'b0, cpu_en = 1'b0, cpu_slow = 1'b0;
  logic ack_o, isr_enter_i, isr_exit_i, in_service_o;
  vipc_req_t irq_req_o;
  logic [23:0] trap_fetch_addr_o, reset_fetch_addr_o;
  int bad_count = 0, samples_checked = 0, lvl = 0, alt = 0;
  int fl[NUM_SRC], en[NUM_SRC], pr[NUM_SRC];
  vipc_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .src_event_i(src_event_i), .trap_event_i(trap_event_i), .isr_enter_i(isr_enter_i),
    .isr_exit_i(isr_exit_i), .trap_enter_i(trap_enter_i), .irq_req_o(irq_req_o),
    .trap_fetch_addr_o(trap_fetch_addr_o), .reset_fetch_addr_o(reset_fetch_addr_o),
    .in_service_o(in_service_o));
  vipc_cpu_model i_cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(irq_req_o), .en_i(cpu_en),
    .slow_i(cpu_slow), .enter_o(isr_enter_i), .exit_o(isr_exit_i));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // ----------
  // bus, compare and closing tasks
  // ----------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    cmp($sformatf("register %h", a), {4'h0, e}, {4'h0, q});
  endtask
  // events at one edge, then wait until the request has settled
  task automatic fire(input logic [NUM_SRC-1:0] x);
    src_event_i <= x;
    for (int v = 0; v < NUM_SRC; v++) fl[v] = fl[v] | int'(x[v] & SRC_IMPL[v]);
    @(posedge clk_i);
    src_event_i <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  function automatic vipc_req_t expect_req();
    vipc_req_t r;
    int b;
    r = '0;
    b = -1;
    for (int v = 0; v < NUM_SRC; v++) begin
      if (fl[v] && en[v] && pr[v] > lvl && (b < 0 || pr[v] > pr[b])) b = v;
    end
    if (b >= 0) r = {1'b1, 7'(b), 4'(pr[b]), (alt ? 24'h000114 : 24'h000014) + 24'(2 * b)};
    return r;
  endfunction
  task automatic end_of_test();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    logic [31:0] e;
    logic [95:0] x;
    int cb[4];
    vipc_req_t r;
    cb = '{4, 2, 3, 1};
    void'($urandom(67));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    cmp("reset fetch", 36'h0, {12'h0, reset_fetch_addr_o});
    wr(8'hfc, 32'hffff);
    for (int i = 0; i < 6; i++) chk_rd(i < 5 ? 8'(4 * i) : 8'hfc, 32'h0);
    for (int j = 0; j < 4; j++) begin
      wr(ADDR_CTRL_TWO, 32'(j % 2) << 15);
      wr(ADDR_CTRL_ONE, 32'h0);
      trap_event_i <= vipc_trap_t'(4'(1 << j));
      @(posedge clk_i);
      trap_event_i <= '0;
      repeat (3) @(posedge clk_i);
      cmp("trap fetch", 36'((j % 2) * 256 + 12 - 2 * j), {12'h0, trap_fetch_addr_o});
      chk_rd(ADDR_CTRL_ONE, 32'(1) << cb[j]);
    end
    for (int it = 0; it < 24; it++) begin
      lvl = $urandom_range(7);
      alt = $urandom_range(1);
      wr(ADDR_ALU_STATUS, 32'(lvl << 5));
      wr(ADDR_CTRL_TWO, 32'(alt << 15));
      for (int g = 0; g < 20; g++) begin
        e = $urandom & 32'hffff7777;
        if (g < 5) wr(ADDR_FLAG_BASE + 8'(4 * g), 32'h0);
        if (g < 5) wr(ADDR_ENABLE_BASE + 8'(4 * g), {16'h0, e[31:16]});
        wr(ADDR_PRIO_BASE + 8'(4 * g), e);
        chk_rd(ADDR_PRIO_BASE + 8'(4 * g), e & 32'h7777);
        for (int k = 0; k < 4; k++) pr[4 * g + k] = int'(e[4 * k +: 3]);
        for (int k = 0; k < 16; k++) if (g < 5) en[16 * g + k] = int'(e[16 + k]);
        for (int k = 0; k < 16; k++) if (g < 5) fl[16 * g + k] = 0;
      end
      x = {$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom};
      fire(x[NUM_SRC-1:0]);
      r = expect_req();
      cmp("request", r, irq_req_o);
      if (r.valid) chk_rd(ADDR_TEST_STATUS, {20'h0, r.level, 1'b0, r.vector});
      for (int g = 0; g < 5; g++) begin
        for (int k = 0; k < 16; k++) e[k] = 1'(fl[16 * g + k]);
        chk_rd(ADDR_FLAG_BASE + 8'(4 * g), {16'h0, e[15:0]});
      end
    end
    // nesting disabled: a higher source must wait for the routine to end
    for (int v = 0; v < NUM_SRC; v++) fl[v] = 0;
    for (int v = 0; v < NUM_SRC; v++) en[v] = int'(v < 2);
    pr[0] = 3;
    pr[1] = 6;
    lvl = 0;
    alt = 0;
    for (int g = 0; g < 5; g++) wr(ADDR_FLAG_BASE + 8'(4 * g), 32'h0);
    for (int g = 0; g < 5; g++) wr(ADDR_ENABLE_BASE + 8'(4 * g), g == 0 ? 32'h3 : 32'h0);
    wr(ADDR_PRIO_BASE, 32'h0063);
    wr(ADDR_ALU_STATUS, 32'h0);
    wr(ADDR_CTRL_TWO, 32'h0);
    wr(ADDR_CTRL_ONE, 32'h8000);
    cpu_slow <= 1'b1;
    cpu_en <= 1'b1;
    fire(80'h1);
    repeat (10) @(posedge clk_i);
    cmp("in service", 36'h1, {35'h0, in_service_o});
    fire(80'h2);
    cmp("request valid", 36'h0, {35'h0, irq_req_o.valid});
    cpu_en <= 1'b0;
    repeat (40) @(posedge clk_i);
    cmp("request", expect_req(), irq_req_o);
    cpu_slow <= 1'b0;
    cpu_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    cmp("in service", 36'h1, {35'h0, in_service_o});
    cpu_en <= 1'b0;
    repeat (12) @(posedge clk_i);
    // trap level, top bit only clearable, level bits frozen by nesting disable
    trap_enter_i <= 1'b1;
    @(posedge clk_i);
    trap_enter_i <= 1'b0;
    @(posedge clk_i);
    chk_rd(ADDR_CORE_CONTROL, 32'h8);
    chk_rd(ADDR_ALU_STATUS, 32'he0);
    wr(ADDR_CORE_CONTROL, 32'h0);
    chk_rd(ADDR_CORE_CONTROL, 32'h0);
    wr(ADDR_CORE_CONTROL, 32'h8);
    chk_rd(ADDR_CORE_CONTROL, 32'h0);
    wr(ADDR_CTRL_ONE, 32'h0);
    wr(ADDR_ALU_STATUS, 32'h40);
    chk_rd(ADDR_ALU_STATUS, 32'h40);
    wr(ADDR_CTRL_ONE, 32'h8000);
    wr(ADDR_ALU_STATUS, 32'h20);
    chk_rd(ADDR_ALU_STATUS, 32'h40);
    end_of_test();
  end
endmodule
bind vipc_ctrl vipc_ctrl_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .irq_req_o(irq_req_o), .trap_fetch_addr_o(trap_fetch_addr_o),
  .reset_fetch_addr_o(reset_fetch_addr_o), .in_service_o(in_service_o));
